// *** shared/codec_dma_defs.svh ***
`ifndef CODEC_DMA_DEFS_SVH
`define CODEC_DMA_DEFS_SVH

// direct register offsets
`define CDP_OFF_INDEX 2'h0
`define CDP_OFF_IDATA 2'h1
`define CDP_OFF_STATUS 2'h2
`define CDP_OFF_DATA 2'h3

// index register values
`define CDP_INDEX_RESET 8'h40
`define CDP_INDEX_BUSY 8'h80

// indirect register indices
`define CDP_IDX_FORMAT 5'h08
`define CDP_IDX_IFCFG 5'h09
`define CDP_IDX_MODEID 5'h0c
`define CDP_IDX_COMPAT 5'h19
`define CDP_IDX_CAPFMT 5'h1c

// field positions, masks and fixed read values
`define CDP_PEN_BIT 0
`define CDP_CEN_BIT 1
`define CDP_SDC_BIT 2
`define CDP_IFCFG_ENABLES 8'h03
`define CDP_FMT_WIDE_BIT 6
`define CDP_FMT_STEREO_BIT 4
`define CDP_MODE_HI_BIT 6
`define CDP_MODE_LO_BIT 5
`define CDP_MODEID_WMASK 8'h60
`define CDP_MODEID_FIXED 8'h8a
`define CDP_COMPAT_VALUE 8'h03

`endif

// *** shared/codec_dma_pkg.sv ***
package codec_dma_pkg;

   typedef enum logic {XF_IDLE, XF_ACTIVE} xfer_state_t;

   typedef struct packed {
      logic [1:0] idx;
      logic done;
   } seq_state_t;

   typedef struct packed {
      logic mode_change_enable;
      logic transfer_request_disable;
      logic [4:0] index;
      logic [31:0][7:0] ireg;
      logic int_flag;
      logic sample_error;
      xfer_state_t play_st;
      xfer_state_t cap_st;
      logic [31:0] play_data;
      logic [31:0] play_sample;
      logic play_valid;
      logic [31:0] cap_data;
      logic cap_fresh;
      logic iow_q;
      logic ior_q;
      logic [7:0] rd_data;
   } port_state_t;

endpackage

// *** src/sample_byte_seq.sv ***
`timescale 1ns/1ps
`include "codec_dma_defs.svh"

// walks the bytes of one sample: left before right, lower before upper
module sample_byte_seq
   import codec_dma_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // sample format
   input wire logic i_wide,
   input wire logic i_stereo,
   // control
   input wire logic i_clear,
   input wire logic i_step,
   // position
   output logic [1:0] o_index,
   output logic o_last,
   output logic o_done,
   output logic o_side,
   output logic o_half
);

   seq_state_t s;
   seq_state_t next_s;
   logic [1:0] last_idx;

   // wide stereo ends on the fourth byte, wide mono or narrow stereo on the second
   assign last_idx = {i_wide & i_stereo, i_wide | i_stereo};
   assign o_index = s.idx;
   assign o_last = (s.idx == last_idx);
   assign o_done = s.done;
   assign o_half = i_wide ? s.idx[0] : 1'b1;
   assign o_side = i_stereo ? ~(i_wide ? s.idx[1] : s.idx[0]) : 1'b1;

   always_comb
   begin
      next_s = s;
      if (i_clear)
      begin
         next_s.idx = 2'h0;
         next_s.done = 1'b0;
      end
      else if (i_step && !s.done)
      begin
         if (o_last)
         begin
            next_s.done = 1'b1;
         end
         else
         begin
            next_s.idx = s.idx + 2'h1;
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

endmodule

// *** src/codec_dma_host_port.sv ***
`timescale 1ns/1ps
`include "codec_dma_defs.svh"

module codec_dma_host_port
   import codec_dma_pkg::*;
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // host bus
   input wire logic [11:0] i_addr,
   input wire logic i_aen,
   input wire logic i_ior_n,
   input wire logic i_iow_n,
   input wire logic [7:0] i_data,
   output logic [7:0] o_data,
   output logic o_data_oe,
   // dma request and acknowledge pairs
   output logic o_drq0,
   output logic o_drq1,
   input wire logic i_dack0_n,
   input wire logic i_dack1_n,
   // configuration
   input wire logic [11:0] i_codec_base,
   input wire logic i_dual_dma,
   input wire logic i_init_busy,
   input wire logic i_software_power_down,
   // converter side
   input wire logic i_play_need,
   input wire logic i_cap_valid,
   input wire logic [31:0] i_cap_sample,
   input wire logic i_int_event,
   input wire logic i_sample_error,
   output logic [31:0] o_play_sample,
   output logic o_play_valid,
   output logic o_dac_mute,
   output logic o_int_status
);

   port_state_t s;
   port_state_t next_s;

   logic dack0;
   logic dack1;
   logic any_dack;
   logic iow_rise;
   logic ior_rise;
   logic pio_sel;
   logic blocked;
   logic single;
   logic mode1;
   logic holdoff;
   logic play_active;
   logic cap_active;
   logic play_dack;
   logic cap_dack;
   logic dma_play_wr;
   logic dma_cap_rd;
   logic pio_play_wr;
   logic pio_cap_rd;
   logic status_rd;
   logic play_start;
   logic cap_start;
   logic [4:0] eff_index;
   logic [7:0] cap_fmt;
   logic [1:0] play_idx;
   logic play_last;
   logic play_done;
   logic play_side;
   logic play_half;
   logic [1:0] cap_idx;
   logic cap_last;
   logic cap_done;
   logic cap_side;
   logic cap_half;
   logic play_step;
   logic cap_step;
   logic [7:0] cap_byte;

   // =====================================================
   // helpers
   // =====================================================
   function automatic logic [7:0] write_mask(input logic [4:0] idx, input logic mode_change_enable);
      logic [7:0] m;
      m = 8'hff;
      if (idx == `CDP_IDX_FORMAT || idx == `CDP_IDX_CAPFMT)
      begin
         m = mode_change_enable ? 8'hff : 8'h00;
      end
      else if (idx == `CDP_IDX_IFCFG)
      begin
         m = mode_change_enable ? 8'hff : `CDP_IFCFG_ENABLES;
      end
      else if (idx == `CDP_IDX_MODEID)
      begin
         m = `CDP_MODEID_WMASK;
      end
      else if (idx == `CDP_IDX_COMPAT)
      begin
         m = 8'h00;
      end
      return m;
   endfunction

   function automatic logic [7:0] read_ireg(input logic [4:0] idx, input logic [7:0] value);
      logic [7:0] r;
      r = value;
      if (idx == `CDP_IDX_MODEID)
      begin
         r = (value & `CDP_MODEID_WMASK) | `CDP_MODEID_FIXED;
      end
      else if (idx == `CDP_IDX_COMPAT)
      begin
         r = `CDP_COMPAT_VALUE;
      end
      return r;
   endfunction

   // =====================================================
   // bus cycle decode
   // =====================================================
   assign dack0 = ~i_dack0_n;
   assign dack1 = ~i_dack1_n;
   assign any_dack = dack0 | dack1;
   assign iow_rise = ~s.iow_q & i_iow_n;
   assign ior_rise = ~s.ior_q & i_ior_n;
   // acknowledged cycles never look at the address
   assign pio_sel = ~i_aen & ~any_dack & (i_addr[11:2] == i_codec_base[11:2]);
   assign blocked = i_init_busy | i_software_power_down;
   assign single = s.ireg[`CDP_IDX_IFCFG][`CDP_SDC_BIT] | ~i_dual_dma;
   assign mode1 = ~s.ireg[`CDP_IDX_MODEID][`CDP_MODE_HI_BIT]
      & ~s.ireg[`CDP_IDX_MODEID][`CDP_MODE_LO_BIT];
   assign eff_index = mode1 ? {1'b0, s.index[3:0]} : s.index;
   assign holdoff = s.transfer_request_disable & s.int_flag;
   assign play_active = (s.play_st == XF_ACTIVE);
   assign cap_active = (s.cap_st == XF_ACTIVE);

   // dma routing onto the two request pairs
   assign play_dack = dack0 & play_active;
   assign cap_dack = cap_active & (single ? dack0 : dack1);
   assign dma_play_wr = play_dack & i_aen & iow_rise;
   assign dma_cap_rd = cap_dack & i_aen & ior_rise;
   assign pio_play_wr = pio_sel & iow_rise & (i_addr[1:0] == `CDP_OFF_DATA);
   assign pio_cap_rd = pio_sel & ior_rise & (i_addr[1:0] == `CDP_OFF_DATA);
   assign status_rd = pio_sel & ior_rise & (i_addr[1:0] == `CDP_OFF_STATUS);

   // a new transfer only starts with no sample in flight
   assign play_start = ~play_active & s.ireg[`CDP_IDX_IFCFG][`CDP_PEN_BIT]
      & i_play_need & ~holdoff;
   assign cap_start = ~cap_active & s.ireg[`CDP_IDX_IFCFG][`CDP_CEN_BIT]
      & s.cap_fresh & ~holdoff
      & (~single | (~play_active & ~play_start));

   assign play_step = dma_play_wr | pio_play_wr;
   assign cap_step = dma_cap_rd | pio_cap_rd;
   assign cap_fmt = mode1 ? s.ireg[`CDP_IDX_FORMAT] : s.ireg[`CDP_IDX_CAPFMT];
   assign cap_byte = s.cap_data[{cap_idx, 3'h0} +: 8];

   // =====================================================
   // sample byte trackers
   // =====================================================
   sample_byte_seq u_play_seq
   (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_wide(s.ireg[`CDP_IDX_FORMAT][`CDP_FMT_WIDE_BIT]),
      .i_stereo(s.ireg[`CDP_IDX_FORMAT][`CDP_FMT_STEREO_BIT]),
      .i_clear(play_start | (status_rd & play_done)),
      .i_step(play_step),
      .o_index(play_idx),
      .o_last(play_last),
      .o_done(play_done),
      .o_side(play_side),
      .o_half(play_half)
   );

   sample_byte_seq u_cap_seq
   (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_wide(cap_fmt[`CDP_FMT_WIDE_BIT]),
      .i_stereo(cap_fmt[`CDP_FMT_STEREO_BIT]),
      .i_clear(i_cap_valid),
      .i_step(cap_step),
      .o_index(cap_idx),
      .o_last(cap_last),
      .o_done(cap_done),
      .o_side(cap_side),
      .o_half(cap_half)
   );

   // =====================================================
   // next state
   // =====================================================
   always_comb
   begin
      next_s = s;
      next_s.iow_q = i_iow_n;
      next_s.ior_q = i_ior_n;
      next_s.play_valid = 1'b0;

      // register writes
      if (pio_sel && iow_rise)
      begin
         case (i_addr[1:0])
            `CDP_OFF_INDEX:
            begin
               if (!blocked)
               begin
                  next_s.mode_change_enable = i_data[6];
                  next_s.transfer_request_disable = i_data[5];
                  next_s.index = i_data[4:0];
               end
            end
            `CDP_OFF_IDATA:
            begin
               next_s.ireg[eff_index] = (s.ireg[eff_index] & ~write_mask(eff_index, s.mode_change_enable))
                  | (i_data & write_mask(eff_index, s.mode_change_enable));
            end
            `CDP_OFF_STATUS:
            begin
               next_s.int_flag = 1'b0;
               next_s.sample_error = 1'b0;
            end
            default:
            begin
               next_s.int_flag = s.int_flag;
            end
         endcase
      end

      // hardware set wins over a clearing write
      if (i_int_event)
      begin
         next_s.int_flag = 1'b1;
      end
      if (i_sample_error)
      begin
         next_s.sample_error = 1'b1;
      end

      // playback byte assembly
      if (play_step && !play_done)
      begin
         next_s.play_data[{play_idx, 3'h0} +: 8] = i_data;
         if (play_last)
         begin
            next_s.play_sample = next_s.play_data;
            next_s.play_valid = 1'b1;
         end
      end

      // playback transfer: request stays up until the sample is complete
      case (s.play_st)
         XF_IDLE:
         begin
            if (play_start)
            begin
               next_s.play_st = XF_ACTIVE;
            end
         end
         XF_ACTIVE:
         begin
            if (dma_play_wr && play_last)
            begin
               next_s.play_st = XF_IDLE;
            end
         end
         default:
         begin
            next_s.play_st = XF_IDLE;
         end
      endcase

      // capture transfer
      case (s.cap_st)
         XF_IDLE:
         begin
            if (cap_start)
            begin
               next_s.cap_st = XF_ACTIVE;
            end
         end
         XF_ACTIVE:
         begin
            if (dma_cap_rd && cap_last)
            begin
               next_s.cap_st = XF_IDLE;
            end
         end
         default:
         begin
            next_s.cap_st = XF_IDLE;
         end
      endcase

      // capture data freshness; a new sample wins over the last read
      if (cap_step && cap_last && !cap_done)
      begin
         next_s.cap_fresh = 1'b0;
      end
      if (i_cap_valid)
      begin
         next_s.cap_data = i_cap_sample;
         next_s.cap_fresh = 1'b1;
      end

      // read data, sampled every cycle
      if (cap_dack)
      begin
         next_s.rd_data = cap_byte;
      end
      else
      begin
         case (i_addr[1:0])
            `CDP_OFF_INDEX:
            begin
               next_s.rd_data = blocked ? `CDP_INDEX_BUSY
                  : {1'b0, s.mode_change_enable, s.transfer_request_disable, s.index};
            end
            `CDP_OFF_IDATA:
            begin
               next_s.rd_data = read_ireg(eff_index, s.ireg[eff_index]);
            end
            `CDP_OFF_STATUS:
            begin
               next_s.rd_data = {cap_half, cap_side, s.cap_fresh, s.sample_error,
                  play_half, play_side, ~play_done, s.int_flag};
            end
            default:
            begin
               next_s.rd_data = cap_byte;
            end
         endcase
      end
   end

   // =====================================================
   // state register
   // =====================================================
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         s <= '0;
         s.mode_change_enable <= 1'(`CDP_INDEX_RESET >> 6);
         s.iow_q <= 1'b1;
         s.ior_q <= 1'b1;
         s.play_st <= XF_IDLE;
         s.cap_st <= XF_IDLE;
      end
      else
      begin
         s <= next_s;
      end
   end

   // =====================================================
   // outputs
   // =====================================================
   assign o_drq0 = play_active | (single & cap_active);
   assign o_drq1 = ~single & cap_active;
   assign o_data = s.rd_data;
   assign o_data_oe = ~i_ior_n & (pio_sel | cap_dack);
   assign o_play_sample = s.play_sample;
   assign o_play_valid = s.play_valid;
   assign o_dac_mute = s.mode_change_enable;
   assign o_int_status = s.int_flag;

endmodule

// *** dv/codec_dma_host_port_checker.sv ***
`timescale 1ns/1ps
module codec_dma_host_port_checker (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // host bus
   input wire logic [11:0] i_addr,
   input wire logic [11:0] i_codec_base,
   input wire logic i_aen,
   input wire logic i_ior_n,
   input wire logic i_iow_n,
   input wire logic [7:0] o_data,
   input wire logic o_data_oe,
   // dma and status
   input wire logic o_drq0,
   input wire logic o_drq1,
   input wire logic i_dack0_n,
   input wire logic i_dack1_n,
   input wire logic i_dual_dma,
   input wire logic i_init_busy,
   input wire logic i_int_event,
   input wire logic o_play_valid,
   input wire logic o_dac_mute,
   input wire logic o_int_status
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_srst);

   logic sel;
   logic dma0;
   logic dma1;
   assign sel = !i_aen && i_dack0_n && i_dack1_n && i_addr[11:2] == i_codec_base[11:2];
   assign dma0 = !i_dack0_n && i_aen;
   assign dma1 = !i_dack1_n && i_aen;

   a_drq0_hold: assert property (
      o_drq0 && !(dma0 && ($rose(i_iow_n) || $rose(i_ior_n))) |=> o_drq0)
      else $error("request 0 dropped early");
   a_drq1_hold: assert property (
      o_drq1 && !(dma1 && ($rose(i_iow_n) || $rose(i_ior_n))) |=> o_drq1)
      else $error("request 1 dropped early");
   a_drq_drop: assert property (
      $fell(o_drq0) |-> $past(dma0) && !($past(i_iow_n, 2) && $past(i_ior_n, 2)))
      else $error("request 0 fell without a byte");
   a_play_done: assert property (
      $fell(o_drq0) && !$past(i_iow_n, 2) |-> o_play_valid)
      else $error("no sample after playback");
   a_int_set: assert property (
      i_int_event |=> o_int_status)
      else $error("interrupt not set");
   a_int_clear: assert property (
      sel && i_addr[1:0] == 2'h2 && $rose(i_iow_n) && !i_int_event |=> !o_int_status)
      else $error("interrupt not cleared");
   a_oe_read: assert property (
      sel && !i_ior_n |-> o_data_oe)
      else $error("read not driven");
   a_oe_idle: assert property (
      i_ior_n || (!sel && i_dack0_n && i_dack1_n) |-> !o_data_oe)
      else $error("bus driven without read");
   a_single_route: assert property (
      !i_dual_dma |-> !o_drq1)
      else $error("request on pair 1 in single mode");
   a_busy_read: assert property (
      i_init_busy && sel && i_addr[1:0] == 2'h0 && !i_ior_n |=> o_data == 8'h80)
      else $error("busy index read wrong");
   a_reset_mute: assert property (
      $fell(i_srst) |-> o_dac_mute)
      else $error("not muted after reset");
endmodule

bind codec_dma_host_port codec_dma_host_port_checker checker_inst (.*);

// *** dv/isa_host_model.sv ***
`timescale 1ns/1ps
// host bus and dma controller; drives just after falling edges
module isa_host_model (
   // clock and bus view
   input wire logic i_clk,
   input wire logic [11:0] i_base,
   input wire logic [7:0] i_rd,
   // bus drive
   output logic [11:0] o_addr,
   output logic o_aen,
   output logic o_ior_n,
   output logic o_iow_n,
   output logic [7:0] o_data,
   output logic o_dack0_n,
   output logic o_dack1_n
);
   initial
   begin
      o_addr = 12'h000;
      o_aen = 1'b0;
      o_ior_n = 1'b1;
      o_iow_n = 1'b1;
      o_data = 8'h00;
      o_dack0_n = 1'b1;
      o_dack1_n = 1'b1;
   end

   // data held past the release edge, then inverted as released lines
   task automatic strobe(input logic wr, input logic [11:0] a, input logic [7:0] d,
         output logic [7:0] q);
      @(negedge i_clk);
      o_addr = a;
      o_data = d;
      o_iow_n = !wr;
      o_ior_n = wr;
      @(negedge i_clk);
      q = i_rd;
      o_iow_n = 1'b1;
      o_ior_n = 1'b1;
      @(negedge i_clk);
      o_data = ~d;
   endtask

   // address points at the index register on purpose
   task automatic dma(input logic ch, input logic wr, input int n, input int lag,
         input logic [31:0] wd, output logic [31:0] rd);
      logic [7:0] b;
      rd = 32'h0;
      repeat (lag) @(negedge i_clk);
      o_aen = 1'b1;
      o_dack0_n = ch;
      o_dack1_n = !ch;
      for (int k = 0; k < n; k++)
      begin
         strobe(wr, {i_base[11:2], 2'h0}, wd[8*k+:8], b);
         rd[8*k+:8] = b;
      end
      o_dack0_n = 1'b1;
      o_dack1_n = 1'b1;
      o_aen = 1'b0;
   endtask
endmodule

// *** dv/codec_dma_host_port_tb.sv ***
`timescale 1ns/1ps
module codec_dma_host_port_tb;
   logic i_core_clk, i_srst, i_aen, i_ior_n, i_iow_n, o_data_oe, o_drq0, o_drq1;
   logic i_dack0_n, i_dack1_n, i_dual_dma, i_init_busy, i_software_power_down;
   logic i_play_need, i_cap_valid, i_int_event, i_sample_error;
   logic o_play_valid, o_dac_mute, o_int_status;
   logic [11:0] i_addr, i_codec_base;
   logic [7:0] i_data, o_data, q;
   logic [31:0] i_cap_sample, o_play_sample, got, lfsr;
   logic [1:0] ctl;
   int num_errors, tests_run;

   codec_dma_host_port dut (.*);
   isa_host_model host (.i_clk(i_core_clk), .i_base(i_codec_base), .i_rd(o_data),
      .o_addr(i_addr), .o_aen(i_aen), .o_ior_n(i_ior_n), .o_iow_n(i_iow_n),
      .o_data(i_data), .o_dack0_n(i_dack0_n), .o_dack1_n(i_dack1_n));

   // ======
   // helpers
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] idx(input logic [1:0] c, input logic [4:0] i);
      return {1'b0, c, i};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         num_errors++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      host.strobe(1'b1, {i_codec_base[11:2], a}, d, q);
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
      host.strobe(1'b0, {i_codec_base[11:2], a}, 8'h00, q);
      chk({24'h0, q & m}, {24'h0, e});
   endtask
   task automatic wi(input logic [4:0] i, input logic [7:0] v);
      wr(2'h0, idx(ctl, i));
      wr(2'h1, v);
   endtask
   task automatic wait_drq(input logic ch);
      int n = 0;
      while ((ch ? o_drq1 : o_drq0) !== 1'b1)
      begin
         @(negedge i_core_clk);
         n++;
         if (n > 60)
         begin
            num_errors++;
            $display("FAIL %0t no request", $time);
            test_done();
         end
      end
   endtask

   initial
   begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   // ======
   // main sequence
   initial
   begin
      i_srst = 1'b1;
      {i_dual_dma, i_init_busy, i_software_power_down, i_play_need} = 4'h8;
      {i_cap_valid, i_int_event, i_sample_error} = 3'h0;
      i_cap_sample = 32'h0;
      i_codec_base = 12'h530;
      lfsr = 32'hf1af;
      ctl = 2'b10;
      num_errors = 0;
      tests_run = 0;
      repeat (3) @(negedge i_core_clk);
      i_srst = 1'b0;
      @(negedge i_core_clk);
      chk({31'h0, o_dac_mute}, 32'h1);
      rd(2'h0, 8'hef, 8'h40);
      i_init_busy = 1'b1;
      wr(2'h0, 8'h1f);
      rd(2'h0, 8'hff, 8'h80);
      i_init_busy = 1'b0;
      i_software_power_down = 1'b1;
      rd(2'h0, 8'hff, 8'h80);
      i_software_power_down = 1'b0;
      rd(2'h0, 8'hef, 8'h40);
      wi(5'h08, 8'h50);
      wi(5'h09, 8'h00);
      ctl = 2'b00;
      wi(5'h08, 8'h00);
      chk({31'h0, o_dac_mute}, 32'h0);
      rd(2'h1, 8'hff, 8'h50);
      wi(5'h0c, 8'h40);
      rd(2'h1, 8'hff, 8'hca);
      wr(2'h0, 8'h19);
      rd(2'h1, 8'hff, 8'h03);
      wi(5'h0c, 8'h00);
      lfsr = nxt(lfsr);
      i_cap_sample = lfsr;
      i_cap_valid = 1'b1;
      @(negedge i_core_clk);
      i_cap_valid = 1'b0;
      rd(2'h2, 8'he0, 8'h60);
      rd(2'h3, 8'hff, lfsr[7:0]);
      rd(2'h2, 8'he0, 8'he0);
      wi(5'h09, 8'h01);
      for (int n = 0; n < 3; n++)
      begin
         lfsr = nxt(lfsr);
         i_play_need = 1'b1;
         wait_drq(1'b0);
         i_play_need = 1'b0;
         host.dma(1'b0, 1'b1, 4, int'(lfsr[9:8]), lfsr, got);
         chk({30'h0, o_play_valid, o_drq0}, 32'h2);
         chk(o_play_sample, lfsr);
      end
      rd(2'h0, 8'hef, 8'h09);
      ctl = 2'b01;
      wr(2'h0, idx(ctl, 5'h09));
      i_int_event = 1'b1;
      @(negedge i_core_clk);
      i_int_event = 1'b0;
      i_play_need = 1'b1;
      repeat (8) @(negedge i_core_clk);
      chk({30'h0, o_drq0, o_int_status}, 32'h1);
      wr(2'h2, 8'h00);
      chk({31'h0, o_int_status}, 32'h0);
      wait_drq(1'b0);
      i_play_need = 1'b0;
      lfsr = nxt(lfsr);
      host.dma(1'b0, 1'b1, 2, 0, lfsr, got);
      wi(5'h09, 8'h00);
      chk({31'h0, o_drq0}, 32'h1);
      host.dma(1'b0, 1'b1, 2, 1, lfsr >> 16, got);
      chk(o_play_sample, lfsr);
      for (int c = 0; c < 3; c++)
      begin
         i_dual_dma = (c != 0);
         ctl = 2'b10;
         wi(5'h09, {5'h0, c == 2, 2'b00});
         ctl = 2'b00;
         lfsr = nxt(lfsr);
         i_cap_sample = lfsr;
         i_cap_valid = 1'b1;
         @(negedge i_core_clk);
         i_cap_valid = 1'b0;
         wi(5'h09, {5'h0, c == 2, 2'b10});
         wait_drq(c == 1);
         chk({30'h0, o_drq1, o_drq0}, (c == 1) ? 32'h2 : 32'h1);
         host.dma(c == 1, 1'b0, 4, int'(lfsr[5:4]), 32'h0, got);
         chk(got, i_cap_sample);
      end
      // single mode still set: data port reads walk the sample as usual
      wi(5'h09, 8'h04);
      lfsr = nxt(lfsr);
      i_cap_sample = lfsr;
      i_cap_valid = 1'b1;
      @(negedge i_core_clk);
      i_cap_valid = 1'b0;
      rd(2'h3, 8'hff, lfsr[7:0]);
      rd(2'h3, 8'hff, lfsr[15:8]);
      // both directions want service on one channel: playback goes first
      i_play_need = 1'b1;
      wi(5'h09, 8'h07);
      wait_drq(1'b0);
      i_play_need = 1'b0;
      lfsr = nxt(lfsr);
      host.dma(1'b0, 1'b1, 4, 0, lfsr, got);
      chk(o_play_sample, lfsr);
      test_done();
   end
endmodule
